// [prap_pkg.sv]
/*
  constants, state codes and carrier types of the paged register access port.
  assumes one 20 MHz system clock; bus pins reach the block unsynchronised.
*/
package prap_pkg;

  // ==========================================================================
  // register map
  localparam logic [15:0] PRAP_CFG_OFFSET = 16'h0026;
  localparam logic [15:0] PRAP_BUSADDR_OFFSET = 16'h0027;
  localparam logic [7:0] PRAP_PAGE_OFFSET = 8'h00FD;
  localparam logic [15:0] PRAP_SPACE_BYTES = 16'h0390;
  localparam int PRAP_MEM_WORDS = 912;
  localparam int PRAP_MEM_AW = 10;

  // ==========================================================================
  // field positions and reset values
  localparam int PRAP_CFG_IFSEL_LSB = 0;
  localparam int PRAP_CFG_TWOBYTE_BIT = 2;
  localparam logic [7:0] PRAP_CFG_RST = 8'h0000;
  localparam logic [6:0] PRAP_BUSADDR_RST = 7'h0009;
  localparam logic [7:0] PRAP_PAGE_RST = 8'h0000;
  localparam logic [3:0] PRAP_BITS_PER_BYTE = 4'h0008;

  // ==========================================================================
  // interface selection codes
  localparam logic [1:0] PRAP_IF_I2C = 2'h0;
  localparam logic [1:0] PRAP_IF_SPI = 2'h1;
  localparam logic [1:0] PRAP_IF_SMBUS = 2'h2;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    PRAP_ST_IDLE = 3'h0,
    PRAP_ST_RECV = 3'h1,
    PRAP_ST_RACK = 3'h3,
    PRAP_ST_SEND = 3'h2,
    PRAP_ST_SACK = 3'h6
  } prap_state_t;

  typedef enum logic [1:0] {
    PRAP_PH_ADDR = 2'h0,
    PRAP_PH_OFF1 = 2'h1,
    PRAP_PH_OFF2 = 2'h3,
    PRAP_PH_DATA = 2'h2
  } prap_phase_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } prap_pins_t;

endpackage : prap_pkg

// [prap_i2c_slave.sv]
/*
  two-wire slave register access port with a 912-byte paged register space.
  assumes pins arrive asynchronously, open-drain wiring outside, and the load
  sequencer reports otp and overall configuration completion on this clock.
*/
// Function
// - config bits one-zero pick active interface
// - blank otp: two-wire, one-byte offsets
// - only selected interface may operate
// - config from otp, slave port, or eeprom
// - eeprom master only after otp enables it
// - 912 bytes in four pages, the fourth only 144 bytes
// - config bit two picks offset width
// - all offset bits address registers
// - one-byte mode uses port page register
// - two-byte mode ignores page register
// - answer programmed 7-bit address, reset 0x09
// - page high byte, offset low byte
// - page register at offset 0xFD anytime
// - sequential read with incrementing addresses
// - sequential write, ack each, increment
// - two-byte: first byte page, second register
// - config changes apply after write completes
`timescale 1ns/1ps
module prap_i2c_slave (
  input wire logic clock,
  input wire logic arst_n,
  input wire prap_pkg::prap_pins_t pinsIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic otpLoadDone,
  input wire logic otpValid,
  input wire logic otpEepromEn,
  input wire logic [7:0] otpCfg,
  input wire logic [6:0] otpBusAddr,
  input wire logic cfgLoadDone,
  output logic eepromMasterEn,
  output logic [1:0] ifSel,
  output logic twoByteMode,
  output logic spiEnable,
  output logic smbusEnable,
  output logic i2cBusy
);
  import prap_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic regHit(input logic [15:0] a, input logic [15:0] off);
    regHit = (a == off);
  endfunction : regHit

  // ==========================================================================
  // pin synchroniser and bus events
  prap_pins_t sync1_ff;
  prap_pins_t sync2_ff;
  prap_pins_t prev_ff;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_ff <= '{scl: 1'b1, sda: 1'b1};
      sync2_ff <= '{scl: 1'b1, sda: 1'b1};
      prev_ff <= '{scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      sync1_ff <= pinsIn;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  wire sclRise = sync2_ff.scl & ~prev_ff.scl;
  wire sclFall = ~sync2_ff.scl & prev_ff.scl;
  wire startSeen = sync2_ff.scl & prev_ff.scl & prev_ff.sda & ~sync2_ff.sda;
  wire stopSeen = sync2_ff.scl & prev_ff.scl & ~prev_ff.sda & sync2_ff.sda;

  // ==========================================================================
  // configuration registers
  logic [7:0] cfg_ff;
  logic [7:0] pendCfg_ff;
  logic [6:0] busAddr_ff;
  logic [6:0] pendAddr_ff;
  logic [7:0] page_ff;
  logic otpSeen_ff;
  logic eeprom_ff;

  assign ifSel = cfg_ff[PRAP_CFG_IFSEL_LSB +: 2];
  assign twoByteMode = cfg_ff[PRAP_CFG_TWOBYTE_BIT];
  wire i2cSelected = (ifSel == PRAP_IF_I2C);
  assign spiEnable = cfgLoadDone & (ifSel == PRAP_IF_SPI);
  assign smbusEnable = cfgLoadDone & (ifSel == PRAP_IF_SMBUS);
  assign eepromMasterEn = eeprom_ff;

  // ==========================================================================
  // protocol state
  prap_state_t state_ff;
  prap_phase_t phase_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] hiOff_ff;
  logic [15:0] addr_ff;
  logic readDir_ff;
  logic masterAck_ff;
  logic drive_ff;
  logic [7:0] mem [PRAP_MEM_WORDS];

  assign i2cBusy = (state_ff != PRAP_ST_IDLE);
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~drive_ff;

  // ==========================================================================
  // address decode
  wire byteDone = (bitCnt_ff == PRAP_BITS_PER_BYTE);
  wire addrMatch = (shift_ff[7:1] == busAddr_ff);
  wire hitPage = (addr_ff[7:0] == PRAP_PAGE_OFFSET);
  wire hitCfg = regHit(addr_ff, PRAP_CFG_OFFSET);
  wire hitBusAddr = regHit(addr_ff, PRAP_BUSADDR_OFFSET);
  wire inSpace = (addr_ff < PRAP_SPACE_BYTES);
  wire [PRAP_MEM_AW-1:0] memIdx = addr_ff[PRAP_MEM_AW-1:0];
  wire [7:0] memRd = inSpace ? mem[memIdx] : 8'h0000;
  wire [7:0] rdData = hitPage ? page_ff :
                      hitCfg ? pendCfg_ff :
                      hitBusAddr ? {1'b0, pendAddr_ff} : memRd;
  wire [15:0] oneByteAddr = {page_ff, shift_ff};
  wire [15:0] twoByteAddr = {hiOff_ff, shift_ff};
  wire dataWrite = (state_ff == PRAP_ST_RECV) & sclFall & byteDone & (phase_ff == PRAP_PH_DATA);
  wire memWrite = dataWrite & inSpace & ~hitPage & ~hitCfg & ~hitBusAddr;
  wire [15:0] addrInc = addr_ff + 16'h0001;

  // ==========================================================================
  // load sequencing and configuration
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      otpSeen_ff <= 1'b0;
      eeprom_ff <= 1'b0;
    end
    else
    begin
      otpSeen_ff <= otpLoadDone;
      eeprom_ff <= otpLoadDone & otpValid & otpEepromEn & ~cfgLoadDone;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_ff <= PRAP_CFG_RST;
      pendCfg_ff <= PRAP_CFG_RST;
      busAddr_ff <= PRAP_BUSADDR_RST;
      pendAddr_ff <= PRAP_BUSADDR_RST;
      page_ff <= PRAP_PAGE_RST;
    end
    else if (otpLoadDone & ~otpSeen_ff & otpValid)
    begin
      cfg_ff <= otpCfg;
      pendCfg_ff <= otpCfg;
      busAddr_ff <= otpBusAddr;
      pendAddr_ff <= otpBusAddr;
    end
    else
    begin
      if (stopSeen & (state_ff != PRAP_ST_IDLE))
      begin
        cfg_ff <= pendCfg_ff;
        busAddr_ff <= pendAddr_ff;
      end
      if (dataWrite & hitPage)
      begin
        page_ff <= shift_ff;
      end
      if (dataWrite & hitCfg)
      begin
        pendCfg_ff <= shift_ff;
      end
      if (dataWrite & hitBusAddr)
      begin
        pendAddr_ff <= shift_ff[6:0];
      end
    end
  end

  // ==========================================================================
  // register memory
  always_ff @(posedge clock)
  begin
    if (memWrite)
    begin
      mem[memIdx] <= shift_ff;
    end
  end

  // ==========================================================================
  // two-wire slave engine
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= PRAP_ST_IDLE;
      phase_ff <= PRAP_PH_ADDR;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h0000;
      tx_ff <= 8'h0000;
      hiOff_ff <= 8'h0000;
      addr_ff <= 16'h0000;
      readDir_ff <= 1'b0;
      masterAck_ff <= 1'b0;
      drive_ff <= 1'b0;
    end
    else if (startSeen & cfgLoadDone & i2cSelected)
    begin
      state_ff <= PRAP_ST_RECV;
      phase_ff <= PRAP_PH_ADDR;
      bitCnt_ff <= 4'h0;
      drive_ff <= 1'b0;
    end
    else if (stopSeen | ~i2cSelected)
    begin
      state_ff <= PRAP_ST_IDLE;
      drive_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        PRAP_ST_RECV:
        begin
          if (sclRise)
          begin
            shift_ff <= {shift_ff[6:0], sync2_ff.sda};
            bitCnt_ff <= bitCnt_ff + 4'h1;
          end
          else if (sclFall & byteDone)
          begin
            state_ff <= PRAP_ST_RACK;
            drive_ff <= 1'b1;
            case (phase_ff)
              PRAP_PH_ADDR:
              begin
                readDir_ff <= shift_ff[0];
                phase_ff <= PRAP_PH_OFF1;
                if (!addrMatch)
                begin
                  state_ff <= PRAP_ST_IDLE;
                  drive_ff <= 1'b0;
                end
              end
              PRAP_PH_OFF1:
              begin
                hiOff_ff <= shift_ff;
                if (twoByteMode)
                begin
                  phase_ff <= PRAP_PH_OFF2;
                end
                else
                begin
                  addr_ff <= oneByteAddr;
                  phase_ff <= PRAP_PH_DATA;
                end
              end
              PRAP_PH_OFF2:
              begin
                addr_ff <= twoByteAddr;
                phase_ff <= PRAP_PH_DATA;
              end
              default:
              begin
                addr_ff <= addrInc;
              end
            endcase
          end
        end
        PRAP_ST_RACK:
        begin
          if (sclFall)
          begin
            bitCnt_ff <= 4'h0;
            if (readDir_ff & (phase_ff == PRAP_PH_OFF1))
            begin
              state_ff <= PRAP_ST_SEND;
              tx_ff <= rdData;
              addr_ff <= addrInc;
              drive_ff <= ~rdData[7];
            end
            else
            begin
              state_ff <= PRAP_ST_RECV;
              drive_ff <= 1'b0;
            end
          end
        end
        PRAP_ST_SEND:
        begin
          if (sclRise)
          begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
          end
          else if (sclFall)
          begin
            if (byteDone)
            begin
              state_ff <= PRAP_ST_SACK;
              drive_ff <= 1'b0;
            end
            else
            begin
              tx_ff <= {tx_ff[6:0], 1'b0};
              drive_ff <= ~tx_ff[6];
            end
          end
        end
        PRAP_ST_SACK:
        begin
          if (sclRise)
          begin
            masterAck_ff <= ~sync2_ff.sda;
          end
          else if (sclFall)
          begin
            bitCnt_ff <= 4'h0;
            // continue on ack, stop on nack
            if (masterAck_ff)
            begin
              state_ff <= PRAP_ST_SEND;
              tx_ff <= rdData;
              addr_ff <= addrInc;
              drive_ff <= ~rdData[7];
            end
            else
            begin
              state_ff <= PRAP_ST_IDLE;
            end
          end
        end
        default:
        begin
          drive_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule : prap_i2c_slave

// [prap_i2c_slave_sva.sv]
/*
  checker of the two-wire register port, bound to its top ports.
  assumes scl idles high between frames.
*/
`timescale 1ns/1ps
module prap_i2c_slave_sva (
  input wire logic clock,
  input wire logic arst_n,
  input wire prap_pkg::prap_pins_t pinsIn,
  input wire logic sdaOe_n,
  input wire logic otpLoadDone,
  input wire logic otpValid,
  input wire logic otpEepromEn,
  input wire logic cfgLoadDone,
  input wire logic eepromMasterEn,
  input wire logic [1:0] ifSel,
  input wire logic twoByteMode,
  input wire logic spiEnable,
  input wire logic smbusEnable,
  input wire logic i2cBusy
);
  import prap_pkg::*;
  // ====
  // properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  eepromGate_a:
    assert property ($past(arst_n) |-> eepromMasterEn == $past(otpLoadDone && otpValid && otpEepromEn && !cfgLoadDone))
    else $error("eeprom master gate wrong");
  ifEnables_a:
    assert property (spiEnable == (cfgLoadDone && ifSel == PRAP_IF_SPI) &&
      smbusEnable == (cfgLoadDone && ifSel == PRAP_IF_SMBUS))
    else $error("interface enable wrong");
  busyOnlySel_a:
    assert property ($rose(i2cBusy) |-> cfgLoadDone && ifSel == PRAP_IF_I2C)
    else $error("engine woke while not selected");
  quietIdle_a:
    assert property (!i2cBusy && !$past(i2cBusy) |-> sdaOe_n)
    else $error("pin driven while idle");
  driveInLow_a:
    assert property ($fell(sdaOe_n) |-> !pinsIn.scl)
    else $error("drive began with scl high");
  holdInHigh_a:
    assert property (pinsIn.scl && $past(pinsIn.scl) |-> $stable(sdaOe_n))
    else $error("drive changed with scl high");
  cfgAtStop_a:
    assert property ($changed(ifSel) || $changed(twoByteMode) |-> pinsIn.scl && pinsIn.sda)
    else $error("config changed inside a frame");
  cfgReset_a:
    assert property ($rose(arst_n) |-> ifSel == PRAP_IF_I2C && !twoByteMode && sdaOe_n)
    else $error("reset config wrong");
endmodule : prap_i2c_slave_sva

bind prap_i2c_slave prap_i2c_slave_sva u_sva (
  .clock(clock),
  .arst_n(arst_n),
  .pinsIn(pinsIn),
  .sdaOe_n(sdaOe_n),
  .otpLoadDone(otpLoadDone),
  .otpValid(otpValid),
  .otpEepromEn(otpEepromEn),
  .cfgLoadDone(cfgLoadDone),
  .eepromMasterEn(eepromMasterEn),
  .ifSel(ifSel),
  .twoByteMode(twoByteMode),
  .spiEnable(spiEnable),
  .smbusEnable(smbusEnable),
  .i2cBusy(i2cBusy)
);

// [prap_host_model.sv]
/*
  two-wire bus master model driving the resolved pins.
  assumes pull-ups on both lines and the 50 ns clock.
*/
`timescale 1ns/1ps
module prap_host_model (
  input wire logic clock,
  input wire logic sdaOe_n,
  input wire logic sdaOut,
  output prap_pkg::prap_pins_t pinsIn
);
  import prap_pkg::*;
  logic sclDrv = 1'b1;
  logic sdaDrv = 1'b1;
  // ====
  // wired-and bus
  assign pinsIn = {sclDrv, sdaDrv & (sdaOe_n | sdaOut)};
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt
  task automatic start();
    sdaDrv <= 1'b1;
    wt(2);
    sclDrv <= 1'b1;
    wt(2);
    sdaDrv <= 1'b0;
    wt(2);
    sclDrv <= 1'b0;
    wt(2);
  endtask : start
  task automatic stop();
    sdaDrv <= 1'b0;
    wt(2);
    sclDrv <= 1'b1;
    wt(2);
    sdaDrv <= 1'b1;
    wt(4);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sdaDrv <= b;
    wt(2);
    sclDrv <= 1'b1;
    wt(2);
    r = pinsIn.sda;
    wt(2);
    sclDrv <= 1'b0;
    wt(2);
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ackN);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ackN);
  endtask : wr_byte
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, r);
  endtask : rd_byte
endmodule : prap_host_model

// [paged_register_access_port_tb.sv]
/*
  self-checking bench of the two-wire register port.
  assumes the host model drives the pins.
*/
`timescale 1ns/1ps
module paged_register_access_port_tb;
  import prap_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic otpLoadDone = 1'b0;
  logic otpValid = 1'b0;
  logic otpEepromEn = 1'b0;
  logic [7:0] otpCfg = 8'h00;
  logic [6:0] otpBusAddr = 7'h15;
  logic cfgLoadDone = 1'b0;
  prap_pins_t pinsIn;
  logic sdaOut, sdaOe_n, eepromMasterEn, twoByteMode, spiEnable, smbusEnable, i2cBusy;
  logic [1:0] ifSel;
  int mismatches = 0;
  int total_checks = 0;
  prap_i2c_slave u_dut (.clock(clock), .arst_n(arst_n), .pinsIn(pinsIn), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .otpLoadDone(otpLoadDone), .otpValid(otpValid), .otpEepromEn(otpEepromEn),
    .otpCfg(otpCfg), .otpBusAddr(otpBusAddr), .cfgLoadDone(cfgLoadDone), .eepromMasterEn(eepromMasterEn),
    .ifSel(ifSel), .twoByteMode(twoByteMode), .spiEnable(spiEnable), .smbusEnable(smbusEnable),
    .i2cBusy(i2cBusy));
  prap_host_model u_host (.clock(clock), .sdaOe_n(sdaOe_n), .sdaOut(sdaOut), .pinsIn(pinsIn));
  initial
  begin
    forever #25 clock = ~clock;
  end
  // ====
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk({5'h00, twoByteMode, ifSel}, 8'h00);
  endtask : do_reset
  task automatic put(input logic [7:0] d, input logic e);
    logic n;
    u_host.wr_byte(d, n);
    chk({7'h00, n}, {7'h00, e});
  endtask : put
  task automatic get(input logic last, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd_byte(last, d);
    chk(d, e);
  endtask : get
  task automatic probe(input logic [7:0] a, input logic e);
    u_host.start();
    put(a, e);
    u_host.stop();
  endtask : probe
  task automatic send_off(input logic wide, input logic [15:0] off);
    u_host.start();
    put(8'h12, 1'b0);
    if (wide)
    begin
      put(off[15:8], 1'b0);
    end
    put(off[7:0], 1'b0);
  endtask : send_off
  task automatic wr_one(input logic wide, input logic [15:0] off, input logic [7:0] d);
    send_off(wide, off);
    put(d, 1'b0);
    u_host.stop();
  endtask : wr_one
  task automatic wr_pair(input logic [15:0] off, input logic [7:0] d0, input logic [7:0] d1);
    send_off(1'b0, off);
    put(d0, 1'b0);
    put(d1, 1'b0);
    u_host.stop();
  endtask : wr_pair
  task automatic rd_pair(input logic wide, input logic [15:0] off, input logic [7:0] e0, input logic [7:0] e1);
    send_off(wide, off);
    u_host.start();
    put(8'h13, 1'b0);
    get(1'b0, e0);
    get(1'b1, e1);
    u_host.stop();
  endtask : rd_pair
  // ====
  // scenarios
  task automatic t_foreign();
    u_host.start();
    put(8'h14, 1'b1);
    chk({7'h00, i2cBusy}, 8'h00);
    u_host.stop();
  endtask : t_foreign
  task automatic t_paged();
    wr_one(1'b0, 16'h00FD, 8'h02);
    wr_pair(16'h0010, 8'hA5, 8'h5A);
    wr_one(1'b0, 16'h00FD, 8'h00);
    wr_pair(16'h0010, 8'h3C, 8'hC3);
    rd_pair(1'b0, 16'h0010, 8'h3C, 8'hC3);
    wr_one(1'b0, 16'h00FD, 8'h03);
    wr_pair(16'h008F, 8'h77, 8'h66);
    rd_pair(1'b0, 16'h008F, 8'h77, 8'h00);
    wr_one(1'b0, 16'h00FD, 8'h02);
    rd_pair(1'b0, 16'h0010, 8'hA5, 8'h5A);
  endtask : t_paged
  task automatic t_wide();
    wr_one(1'b0, 16'h00FD, 8'h00);
    send_off(1'b0, 16'h0026);
    put(8'h04, 1'b0);
    chk({7'h00, twoByteMode}, 8'h00);
    u_host.stop();
    chk({7'h00, twoByteMode}, 8'h01);
    rd_pair(1'b1, 16'h0210, 8'hA5, 8'h5A);
  endtask : t_wide
  task automatic t_select();
    for (int c = 1; c <= 3; c++)
    begin
      do_reset();
      wr_one(1'b0, 16'h0026, {6'h00, c[1:0]});
      chk({6'h00, spiEnable, smbusEnable}, {6'h00, c[1:0] == PRAP_IF_SPI, c[1:0] == PRAP_IF_SMBUS});
      probe(8'h12, 1'b1);
    end
  endtask : t_select
  task automatic t_otp();
    do_reset();
    cfgLoadDone <= 1'b0;
    otpLoadDone <= 1'b0;
    otpValid <= 1'b1;
    otpEepromEn <= 1'b1;
    otpCfg <= 8'h04;
    @(posedge clock);
    otpLoadDone <= 1'b1;
    repeat (3) @(posedge clock);
    chk({7'h00, eepromMasterEn}, 8'h01);
    chk({7'h00, twoByteMode}, 8'h01);
    probe(8'h2A, 1'b1);
    cfgLoadDone <= 1'b1;
    repeat (3) @(posedge clock);
    chk({7'h00, eepromMasterEn}, 8'h00);
    probe(8'h2A, 1'b0);
    probe(8'h12, 1'b1);
  endtask : t_otp
  initial
  begin
    do_reset();
    otpLoadDone <= 1'b1;
    cfgLoadDone <= 1'b1;
    repeat (4) @(posedge clock);
    t_foreign();
    t_paged();
    t_wide();
    t_select();
    t_otp();
    wrap_up();
  end
endmodule : paged_register_access_port_tb
